// ### core/ppd_pkg.sv
package ppd_pkg;

    // Number of user I/O lanes watched by the block
    localparam int IO_WIDTH = 32;

    // Input stable time before the power-down pin rises, per speed grade
    localparam int SETUP_FAST_NS = 15;
    localparam int SETUP_SLOW_NS = 20;

    // Time after the pin rises before inputs become don't care
    localparam int DONTCARE_FAST_NS = 25;
    localparam int DONTCARE_SLOW_NS = 30;

    // Wake-up time after the pin falls
    localparam int WAKE_US = 1;

    // Clock period
    localparam int CLK_PERIOD_NS = 8;

    // Longest times round down, none below one cycle
    localparam int DONTCARE_CYCLES =
        (DONTCARE_SLOW_NS / CLK_PERIOD_NS) < 1 ? 1 : (DONTCARE_SLOW_NS / CLK_PERIOD_NS);
    localparam int WAKE_CYCLES =
        ((WAKE_US * 1000) / CLK_PERIOD_NS) < 1 ? 1 : ((WAKE_US * 1000) / CLK_PERIOD_NS);

    // Counter width for the wake-up count
    localparam int CNT_W = 8;

    // Reset values
    localparam logic [IO_WIDTH-1:0] RESET_DATA = 32'h0000_0000;

    // Operating states, one-hot
    typedef enum logic [2:0] {
        PPD_RUN = 3'b001,  // Normal operation
        PPD_DOWN = 3'b010, // Frozen
        PPD_WAKE = 3'b100  // Leaving power-down
    } ppd_state_t;

    // Pin-side signals of the user array
    typedef struct packed {
        logic [IO_WIDTH-1:0] data;   // Data toward the pins
        logic [IO_WIDTH-1:0] enable; // Output enables, high drives the pin
    } ppd_pins_t;

    // Whole state of the block
    typedef struct packed {
        ppd_state_t state;        // Operating state
        logic [CNT_W-1:0] count;  // Wake-up count
        ppd_pins_t held;          // Registered output values and enables
        logic [IO_WIDTH-1:0] keep; // Pin-keeper levels
        logic [IO_WIDTH-1:0] feedback; // Buried feedback to the array
        logic downFlag;           // Power-down indication
        logic wakeValid;          // Outputs show normal operation
    } ppd_regs_t;

endpackage

// ### core/ppd_power_down.sv
`timescale 1ns/100ps
// What this block does
// - Pin controls power-down only when option set
// - Pin high enters power-down, low runs
// - Hold all registers and outputs when down
// - High-impedance outputs stay released while down
// - Ignore inputs, enables, clocks while down
// - Pin-keeper latches stay active while down
// - Pin macrocell still feeds buried feedback
// - Inputs are don't care after pin high
// - Valid outputs within wake time after low
module ppd_power_down #(
    parameter int WIDTH = ppd_pkg::IO_WIDTH
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic powerDownEnable,
    input wire logic power_down_pin,
    input wire logic [WIDTH-1:0] arrayData,
    input wire logic [WIDTH-1:0] arrayEnable,
    input wire logic [WIDTH-1:0] pinLevel,
    input wire logic arrayClockEn,
    output logic [WIDTH-1:0] pinData,
    output logic [WIDTH-1:0] pinEnable,
    output logic [WIDTH-1:0] keeperLevel,
    output logic [WIDTH-1:0] arrayFeedback,
    output logic poweredDown,
    output logic outputsValid
);

    // Current and next state
    ppd_pkg::ppd_regs_t r;
    ppd_pkg::ppd_regs_t next_r;

    // True while the block holds its state, down or waking
    function automatic logic ppdHolding(input ppd_pkg::ppd_state_t s);
        return (s == ppd_pkg::PPD_DOWN) || (s == ppd_pkg::PPD_WAKE);
    endfunction

    // Power-down request is qualified by the option
    logic downReq;
    assign downReq = powerDownEnable & power_down_pin;

    // Next-state logic
    always_comb begin
        next_r = r;
        case (r.state)
            ppd_pkg::PPD_RUN: begin
                // Normal capture of array values
                if (arrayClockEn) begin
                    next_r.held.data = arrayData;
                    next_r.held.enable = arrayEnable;
                    next_r.feedback = arrayData;
                end
                next_r.keep = pinLevel;
                next_r.wakeValid = 1'b1;
                if (downReq) begin
                    // Freeze everything as captured now
                    next_r.state = ppd_pkg::PPD_DOWN;
                    next_r.downFlag = 1'b1;
                end
            end
            ppd_pkg::PPD_DOWN: begin
                // Array inputs ignored, values stay put; only the qualified pin is watched
                if (!downReq) begin
                    next_r.state = ppd_pkg::PPD_WAKE;
                    next_r.count = '0;
                    next_r.downFlag = 1'b0;
                    next_r.wakeValid = 1'b0;
                end
            end
            ppd_pkg::PPD_WAKE: begin
                // Held state kept, no reinitialisation
                if (downReq) begin
                    next_r.state = ppd_pkg::PPD_DOWN;
                    next_r.downFlag = 1'b1;
                end else if (r.count == ppd_pkg::CNT_W'(ppd_pkg::WAKE_CYCLES - 1)) begin
                    next_r.state = ppd_pkg::PPD_RUN;
                    next_r.wakeValid = 1'b1;
                end else begin
                    next_r.count = r.count + 1'b1;
                end
            end
            default: begin
                next_r.state = ppd_pkg::PPD_RUN;
            end
        endcase
    end

    // State register
    always_ff @(posedge clock) begin
        if (rst) begin
            r <= '{state: ppd_pkg::PPD_RUN, count: '0,
                   held: '{data: ppd_pkg::RESET_DATA, enable: ppd_pkg::RESET_DATA},
                   keep: ppd_pkg::RESET_DATA, feedback: ppd_pkg::RESET_DATA,
                   downFlag: 1'b0, wakeValid: 1'b1};
        end else begin
            r <= next_r;
        end
    end

    // Outputs straight from flip-flops
    assign pinData = r.held.data;
    assign pinEnable = r.held.enable;
    assign keeperLevel = r.keep;
    assign arrayFeedback = r.feedback;
    assign poweredDown = r.downFlag;
    assign outputsValid = r.wakeValid;

    // Outputs frozen during power-down
    a_frozen_data: assert property (@(posedge clock) disable iff (rst)
        (r.state == ppd_pkg::PPD_DOWN && $past(r.state) == ppd_pkg::PPD_DOWN)
        |-> $stable(pinData) && $stable(pinEnable))
        else $error("outputs changed while powered down");

    // Released lane zero stays released while down
    a_hiz_kept: assert property (@(posedge clock) disable iff (rst)
        (poweredDown && !pinEnable[0]) |=> (!poweredDown || !pinEnable[0]))
        else $error("released output driven while down");

    // Keeper levels frozen while down
    a_keeper_hold: assert property (@(posedge clock) disable iff (rst)
        poweredDown |=> (!poweredDown || $stable(keeperLevel)))
        else $error("keeper level moved while down");

    // Feedback frozen while down
    a_feedback_hold: assert property (@(posedge clock) disable iff (rst)
        poweredDown |=> (!poweredDown || $stable(arrayFeedback)))
        else $error("feedback moved while down");

    // No power-down without the option
    a_option_gate: assert property (@(posedge clock) disable iff (rst)
        (!powerDownEnable && r.state == ppd_pkg::PPD_RUN) |=> !poweredDown)
        else $error("powered down without option");

    // Qualified pin high powers down next cycle
    a_enter_down: assert property (@(posedge clock) disable iff (rst)
        (powerDownEnable && power_down_pin) |=> poweredDown)
        else $error("pin high did not power down");

    // Inputs cannot reach the frozen state
    a_inputs_ignored: assert property (@(posedge clock) disable iff (rst)
        (poweredDown && downReq) |=> ($stable(pinData) && poweredDown))
        else $error("input reached state while down");

    // Freeze lands inside the don't care time
    a_dontcare_time: assert property (@(posedge clock) disable iff (rst)
        $rose(downReq) |-> ##[1:3] poweredDown)
        else $error("not frozen within don't care time");

    // Outputs valid within the wake time
    a_wake_time: assert property (@(posedge clock) disable iff (rst)
        $fell(poweredDown) && !downReq |-> ##[1:125] (outputsValid || poweredDown))
        else $error("outputs not valid within wake time");

    // Wake keeps the held values
    a_no_reinit: assert property (@(posedge clock) disable iff (rst)
        $fell(poweredDown) |-> $stable(pinData) && $stable(pinEnable))
        else $error("state altered on wake");

    // Running array values reach the output registers
    a_run_capture: assert property (@(posedge clock) disable iff (rst)
        (r.state == ppd_pkg::PPD_RUN && arrayClockEn)
        |=> (pinData == $past(arrayData)) && (pinEnable == $past(arrayEnable)))
        else $error("array values not captured while running");

    // Buried feedback follows the captured data
    a_feedback_track: assert property (@(posedge clock) disable iff (rst)
        (r.state == ppd_pkg::PPD_RUN && arrayClockEn) |=> arrayFeedback == $past(arrayData))
        else $error("feedback not loaded while running");

    // Keepers follow the pins while running
    a_keeper_track: assert property (@(posedge clock) disable iff (rst)
        r.state == ppd_pkg::PPD_RUN |=> keeperLevel == $past(pinLevel))
        else $error("keeper level not tracking pins");

    // No capture while down or waking
    a_hold_output: assert property (@(posedge clock) disable iff (rst)
        ppdHolding(r.state) |=> $stable(pinData) && $stable(pinEnable))
        else $error("outputs moved while holding");

    // Keepers and feedback untouched while holding
    a_hold_keeper: assert property (@(posedge clock) disable iff (rst)
        ppdHolding(r.state) |=> $stable(keeperLevel) && $stable(arrayFeedback))
        else $error("keeper or feedback moved while holding");

    // Every lane enable frozen while down
    a_hiz_lanes: assert property (@(posedge clock) disable iff (rst)
        poweredDown |=> (!poweredDown || $stable(pinEnable)))
        else $error("output enable moved while down");

    // Outputs flagged invalid during the wake count
    a_wake_invalid: assert property (@(posedge clock) disable iff (rst)
        r.state == ppd_pkg::PPD_WAKE |-> !outputsValid)
        else $error("outputs flagged valid during wake");

    // Outputs flagged valid in normal operation
    a_run_valid: assert property (@(posedge clock) disable iff (rst)
        r.state == ppd_pkg::PPD_RUN |-> outputsValid)
        else $error("outputs flagged invalid while running");

    // Last wake count returns to normal operation
    a_wake_exit: assert property (@(posedge clock) disable iff (rst)
        (r.state == ppd_pkg::PPD_WAKE && !downReq
         && r.count == ppd_pkg::CNT_W'(ppd_pkg::WAKE_CYCLES - 1))
        |=> (outputsValid && !poweredDown))
        else $error("wake count did not end");

    // Pin high during wake powers down again
    a_wake_reenter: assert property (@(posedge clock) disable iff (rst)
        (r.state == ppd_pkg::PPD_WAKE && downReq) |=> poweredDown)
        else $error("pin high during wake ignored");

    // Indication matches the frozen state
    a_down_flag: assert property (@(posedge clock) disable iff (rst)
        poweredDown == (r.state == ppd_pkg::PPD_DOWN))
        else $error("indication out of step with state");

    // Dropping the option releases power-down
    a_option_off: assert property (@(posedge clock) disable iff (rst)
        (!powerDownEnable && poweredDown) |=> !poweredDown)
        else $error("stayed down without option");

    // Wake count never passes its end
    a_count_bound: assert property (@(posedge clock) disable iff (rst)
        r.count <= ppd_pkg::CNT_W'(ppd_pkg::WAKE_CYCLES - 1))
        else $error("wake count out of range");

endmodule

// ### verif/ppd_far_side.sv
`timescale 1ns/100ps
// Far-side logic: random array traffic, held steady on request
module ppd_far_side (
    input wire logic clock,
    input wire logic quiet,
    output logic [31:0] data,
    output logic [31:0] enable,
    output logic [31:0] level,
    output logic clockEn
);
    integer seed = 10103; // Fixed seed, repeatable run
    // Never looks at the pin; steady while quiet
    always @(posedge clock) begin
        if (!quiet) begin
            data <= 32'($random(seed));
            enable <= 32'($random(seed));
            level <= 32'($random(seed));
            clockEn <= 1'($random(seed));
        end
    end
endmodule

// ### verif/ppd_power_down_tb.sv
`timescale 1ns/100ps
// Bench with a cycle model of freeze and wake
module ppd_power_down_tb;
    logic clock = 0;
    logic rst = 1;
    logic opt = 0;
    logic pin = 0;
    logic quiet = 0;
    logic [31:0] dat, ena, lvl, pinData, pinEn, keep, fb, fbHeld;
    logic [31:0] mData, mEn, mKeep, mFb;
    logic hung = 0; // Set when a wake never ends
    logic down, valid, clkEn, mDown, mWake, mValid, wasDown;
    int cnt, k;
    int error_cnt = 0;
    int tests_run = 0;
    initial forever #4 clock = ~clock;
    ppd_far_side u_ppd_far_side (.clock(clock), .quiet(quiet), .data(dat),
        .enable(ena), .level(lvl), .clockEn(clkEn));
    ppd_power_down u_ppd_power_down (.clock(clock), .rst(rst),
        .powerDownEnable(opt), .power_down_pin(pin), .arrayData(dat),
        .arrayEnable(ena), .pinLevel(lvl), .arrayClockEn(clkEn),
        .pinData(pinData), .pinEnable(pinEn), .keeperLevel(keep),
        .arrayFeedback(fb), .poweredDown(down), .outputsValid(valid));
    // Reference model of capture, freeze and wake count
    always @(posedge clock) begin
        if (rst) begin
            {mData, mEn, mKeep, mFb} <= '0;
            {mDown, mWake, mValid} <= 3'b001;
        end else if (!mDown && !mWake) begin
            if (clkEn) begin
                mData <= dat;
                mEn <= ena;
                mFb <= dat;
            end
            mKeep <= lvl;
            mDown <= opt & pin;
        end else if (mDown) begin
            mDown <= opt & pin;
            mWake <= !(opt & pin);
            mValid <= 1'b0;
            cnt <= 0;
        end else if (opt & pin) begin
            mDown <= 1'b1;
            mWake <= 1'b0;
        end else begin
            cnt <= cnt + 1;
            mWake <= !wakeDone(cnt);
            mValid <= wakeDone(cnt);
        end
    end
    // Last wake count before outputs are valid again
    function automatic bit wakeDone(input int c);
        return c == ppd_pkg::WAKE_CYCLES - 1;
    endfunction
    task automatic check(input logic [127:0] got, input logic [127:0] exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %0t mismatch got %h exp %h", $time, got, exp);
        end
    endtask
    // Compare on the falling edge, once updates have settled
    always @(negedge clock) begin
        if (!rst) begin
            check({pinData, pinEn}, {mData, mEn});
            check({keep, down}, {mKeep, mDown});
            check(fb, mFb);
            if (!mDown)
                check(valid, mValid);
            if (mDown && wasDown)
                check(fb, fbHeld);
            fbHeld = fb;
            wasDown = mDown;
        end
    end
    task automatic print_verdict();
        $display("errors %0d checks %0d", error_cnt, tests_run);
        if (error_cnt == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // One power-down round; round 1 re-enters during wake
    task automatic nap(input int i);
        quiet <= 1'b1;
        repeat (3) @(posedge clock);
        pin <= 1'b1;
        repeat (4) @(posedge clock);
        quiet <= 1'b0;
        repeat (10 + 7 * i) @(posedge clock);
        pin <= 1'b0;
        if (i == 1) begin
            repeat (57) @(posedge clock);
            quiet <= 1'b1;
            repeat (3) @(posedge clock);
            pin <= 1'b1;
            repeat (5) @(posedge clock);
            quiet <= 1'b0;
            pin <= 1'b0;
        end
        repeat (2) @(posedge clock);
        // Look at the valid flag only once it has settled
        @(negedge clock);
        for (k = 0; k < 200 && valid !== 1'b1; k++)
            @(negedge clock);
        if (valid !== 1'b1) begin
            error_cnt++;
            $display("ERROR %0t wake never ended", $time);
            hung = 1'b1;
        end
        repeat (20) @(posedge clock);
    endtask
    initial begin
        repeat (8) @(posedge clock);
        rst <= 1'b0;
        repeat (20) @(posedge clock);
        pin <= 1'b1;
        repeat (20) @(posedge clock);
        pin <= 1'b0;
        opt <= 1'b1;
        for (int i = 0; i < 6 && !hung; i++)
            nap(i);
        print_verdict();
    end
endmodule
